// >>> src/jtag_prog_defs.svh
/*
 * Constants for the test port programming path: instruction codes,
 * data register lengths, register offsets and timing counts.
 * Assumes a 10 MHz core clock and byte addressing on the register bus.
 */
`ifndef JTAG_PROG_DEFS_SVH
`define JTAG_PROG_DEFS_SVH

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define IR_LEN 4
`define IR_CHAIN_RESET 4'hC
`define IR_PROG_UNLOCK 4'h4
`define IR_PROG_COMMAND 4'h5
`define IR_PAGE_LOAD 4'h6
`define IR_PAGE_READ 4'h7
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1

// ----------------------------------------------------------------
// Data register layout
// ----------------------------------------------------------------
`define UNLOCK_LEN 16
`define UNLOCK_SIGNATURE 16'hA370
`define CMD_LEN 15
`define BYTE_LEN 8
`define ADDR_LEN 16

// ----------------------------------------------------------------
// Register map (byte offsets) and field positions
// ----------------------------------------------------------------
`define OFS_CORE_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_WORD_ADDR 4'h8
`define OFS_COMMAND 4'hC
`define CTRL_DISABLE_BIT 0
`define CTRL_RESET 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 10
`define DISABLE_CLR_CLKS 2
`define PAGE_WR_TCK 11
`define RST_TMO_US_0 1
`define RST_TMO_US_1 10
`define RST_TMO_US_2 100
`define RST_TMO_US_3 400
`define RST_TMO_CYC_0 (`RST_TMO_US_0 * `CLK_MHZ)
`define RST_TMO_CYC_1 (`RST_TMO_US_1 * `CLK_MHZ)
`define RST_TMO_CYC_2 (`RST_TMO_US_2 * `CLK_MHZ)
`define RST_TMO_CYC_3 (`RST_TMO_US_3 * `CLK_MHZ)

`endif

// >>> src/jtag_prog_pkg.sv
/*
 * Types shared by the programming path: the test access port states.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package jtag_prog_pkg;
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SH_DR = 4'h4,
		TAP_EX1_DR = 4'h5,
		TAP_PA_DR = 4'h6,
		TAP_EX2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'hA,
		TAP_SH_IR = 4'hB,
		TAP_EX1_IR = 4'hC,
		TAP_PA_IR = 4'hD,
		TAP_EX2_IR = 4'hE,
		TAP_UPD_IR = 4'hF
	} tap_state_t;
endpackage

`default_nettype wire

// >>> src/jtag_prog_path.sv
/*
 * Test port programming data path: TAP controller sampled on the core
 * clock, instruction register, reset chain, unlock register, command and
 * byte registers, page load/read sequencing and an AXI4-Lite slave.
 * Assumes TCK/TMS/TDI/reset pins are asynchronous and TCK is slower than
 * a quarter of CLOCK_IN; the array answers combinationally.
 */
// Behaviour
// - Path usable only with fuse and disable clear
// - Reset low clears disable bit after two clocks
// - All shift registers move LSB first
// - Four-bit instruction register selects data register
// - Run-Test/Idle generates internal programming pulses
// - Code 0xC selects one-bit reset chain
// - Reset chain one holds device in reset
// - Reset time-out follows chain release
// - Code 0x4 unlocks on signature match
// - Signature 0xA370, enable register clears at reset
// - Code 0x5 captures previous command result
// - Command shifts out result, update drives array
// - Each idle pass from Update-DR executes the applied command
// - Code 0x6 byte register is command low byte
// - Page load update writes page buffer promptly
// - Page load alternates low then high byte
// - Counter pre-increments before low byte, not first
// - Code 0x7 captures array byte, low first
// - Counter post-increments after every high byte
`include "jtag_prog_defs.svh"
`default_nettype none

module jtag_prog_path
	import jtag_prog_pkg::*;
(
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic TCK_IN,
	input wire logic TMS_IN,
	input wire logic TDI_IN,
	output logic TDO_OUT,
	output logic TDO_EN_N_OUT,
	input wire logic EXT_RESET_N_IN,
	input wire logic TEST_PORT_ENABLE_FUSE_IN,
	input wire logic [1:0] RESET_TIMEOUT_FUSE_IN,
	output logic DEVICE_RESET_OUT,
	output logic [14:0] ARRAY_CMD_OUT,
	output logic ARRAY_EXEC_OUT,
	input wire logic [14:0] ARRAY_RESULT_IN,
	output logic PAGE_WR_OUT,
	output logic PAGE_HIGH_OUT,
	output logic [7:0] PAGE_DATA_OUT,
	output logic [15:0] WORD_ADDR_OUT,
	input wire logic [15:0] ARRAY_WORD_IN,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	// ----------------------------------------------------------------
	// Pin synchronisers and TCK edge detection
	// ----------------------------------------------------------------
	logic [1:0] tck_s_reg, tms_s_reg, tdi_s_reg, rstn_s_reg, fuse_s_reg;
	logic [1:0] tmo_s1_reg, tmo_s2_reg;
	logic tck_d_reg;
	logic tck_rise, tck_fall;

	// Edges are only seen reliably while TCK stays well below CLOCK_IN
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tck_s_reg <= 2'h0;
			tms_s_reg <= 2'h3;
			tdi_s_reg <= 2'h0;
			rstn_s_reg <= 2'h3;
			fuse_s_reg <= 2'h0;
			tmo_s1_reg <= 2'h0;
			tmo_s2_reg <= 2'h0;
			tck_d_reg <= 1'b0;
		end else begin
			tck_s_reg <= {tck_s_reg[0], TCK_IN};
			tms_s_reg <= {tms_s_reg[0], TMS_IN};
			tdi_s_reg <= {tdi_s_reg[0], TDI_IN};
			rstn_s_reg <= {rstn_s_reg[0], EXT_RESET_N_IN};
			fuse_s_reg <= {fuse_s_reg[0], TEST_PORT_ENABLE_FUSE_IN};
			tmo_s1_reg <= RESET_TIMEOUT_FUSE_IN;
			tmo_s2_reg <= tmo_s1_reg;
			tck_d_reg <= tck_s_reg[1];
		end
	end

	logic tms, tdi, ext_reset_n, fuse_prog;
	assign tms = tms_s_reg[1];
	assign tdi = tdi_s_reg[1];
	assign ext_reset_n = rstn_s_reg[1];
	assign fuse_prog = fuse_s_reg[1];
	assign tck_rise = tck_s_reg[1] & ~tck_d_reg;
	assign tck_fall = ~tck_s_reg[1] & tck_d_reg;

	// ----------------------------------------------------------------
	// Disable bit and port enable
	// ----------------------------------------------------------------
	logic disable_reg;
	logic [1:0] dis_cnt_reg;
	logic port_enable;
	logic ctrl_wr;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	// Held external reset counts two chip clocks, then frees the pins
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			disable_reg <= `CTRL_RESET;
			dis_cnt_reg <= 2'h0;
		end else begin
			if (ext_reset_n || !disable_reg) begin
				dis_cnt_reg <= 2'h0;
			end else if (dis_cnt_reg != 2'(`DISABLE_CLR_CLKS)) begin
				dis_cnt_reg <= dis_cnt_reg + 2'h1;
			end
			if (disable_reg && !ext_reset_n && dis_cnt_reg == 2'(`DISABLE_CLR_CLKS)) begin
				disable_reg <= 1'b0; // Hardware clear beats a write in the same cycle
			end else if (ctrl_wr && wstrb_reg[0]) begin
				disable_reg <= wdata_reg[`CTRL_DISABLE_BIT];
			end
		end
	end

	assign port_enable = fuse_prog & ~disable_reg;

	// ----------------------------------------------------------------
	// TAP controller
	// ----------------------------------------------------------------
	tap_state_t tap_reg, tap_next;
	always_comb begin
		unique case (tap_reg)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR: tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR: tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	// A locked port keeps the TAP parked in reset
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tap_reg <= TAP_RESET;
		end else if (!port_enable) begin
			tap_reg <= TAP_RESET;
		end else if (tck_rise) begin
			tap_reg <= tap_next;
		end
	end

	port_gate_a: assert property (!port_enable |=> tap_reg == TAP_RESET)
		else $error("TAP left reset while port locked");

	logic cap_dr, sh_dr, upd_dr, sh_ir, upd_ir, idle_entry;
	assign cap_dr = tck_rise && tap_reg == TAP_CAP_DR;
	assign sh_dr = tck_rise && tap_reg == TAP_SH_DR;
	assign upd_dr = tck_rise && tap_reg == TAP_UPD_DR;
	assign sh_ir = tck_rise && tap_reg == TAP_SH_IR;
	assign upd_ir = tck_rise && tap_reg == TAP_UPD_IR;
	assign idle_entry = tck_rise && tap_reg != TAP_IDLE && tap_next == TAP_IDLE;

	// ----------------------------------------------------------------
	// Instruction register
	// ----------------------------------------------------------------
	logic [3:0] ir_sr_reg, ir_reg;
	// Four-bit code picks the data register, shifted LSB first
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ir_sr_reg <= 4'h0;
			ir_reg <= `IR_BYPASS;
		end else if (tap_reg == TAP_RESET) begin
			ir_reg <= `IR_BYPASS;
		end else if (tck_rise && tap_reg == TAP_CAP_IR) begin
			ir_sr_reg <= `IR_CAPTURE;
		end else if (sh_ir) begin
			ir_sr_reg <= {tdi, ir_sr_reg[3:1]};
		end else if (upd_ir) begin
			ir_reg <= ir_sr_reg;
		end
	end

	lsb_first_a: assert property (sh_ir |=> ir_sr_reg[3] == $past(tdi))
		else $error("IR shift not LSB first");

	// ----------------------------------------------------------------
	// Data registers
	// ----------------------------------------------------------------
	logic chain_reg, bypass_reg, prog_mode_reg, hi_sel_reg, first_reg;
	logic [15:0] enable_reg, addr_reg;
	logic [14:0] cmd_sr_reg, cmd_reg;
	logic sel_chain, sel_unlock, sel_cmd, sel_load, sel_read;
	logic addr_wr;

	assign sel_chain = ir_reg == `IR_CHAIN_RESET;
	assign sel_unlock = ir_reg == `IR_PROG_UNLOCK;
	assign sel_cmd = ir_reg == `IR_PROG_COMMAND && prog_mode_reg;
	assign sel_load = ir_reg == `IR_PAGE_LOAD && prog_mode_reg;
	assign sel_read = ir_reg == `IR_PAGE_READ && prog_mode_reg;

	// Reset chain: the bit itself is the reset, no update latch
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			chain_reg <= 1'b0;
			bypass_reg <= 1'b0;
		end else if (sh_dr) begin
			if (sel_chain) begin
				chain_reg <= tdi;
			end
			bypass_reg <= tdi;
		end
	end

	// Unlock register, cleared only by power-on reset
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			enable_reg <= 16'h0000;
			prog_mode_reg <= 1'b0;
		end else if (sh_dr && sel_unlock) begin
			enable_reg <= {tdi, enable_reg[15:1]};
		end else if (upd_dr && sel_unlock) begin
			prog_mode_reg <= enable_reg == `UNLOCK_SIGNATURE;
		end
	end

	unlock_a: assert property (upd_dr && sel_unlock |=>
		prog_mode_reg == ($past(enable_reg) == `UNLOCK_SIGNATURE))
		else $error("Programming mode disagrees with signature");

	// Command register; byte register is its low eight bits
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cmd_sr_reg <= 15'h0000;
			cmd_reg <= 15'h0000;
		end else if (cap_dr && sel_cmd) begin
			cmd_sr_reg <= ARRAY_RESULT_IN;
		end else if (cap_dr && sel_read) begin
			cmd_sr_reg[7:0] <= hi_sel_reg ? ARRAY_WORD_IN[15:8] : ARRAY_WORD_IN[7:0];
		end else if (sh_dr && sel_cmd) begin
			cmd_sr_reg <= {tdi, cmd_sr_reg[14:1]};
		end else if (sh_dr && (sel_load || sel_read)) begin
			cmd_sr_reg[7:0] <= {tdi, cmd_sr_reg[7:1]};
		end else if (upd_dr && sel_cmd) begin
			cmd_reg <= cmd_sr_reg;
		end
	end

	// ----------------------------------------------------------------
	// Page sequencing: byte alternation and word address counter
	// ----------------------------------------------------------------
	logic wr_pend_reg;
	logic [7:0] temp_reg;
	// A fresh instruction restarts at the low byte
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			hi_sel_reg <= 1'b0;
			first_reg <= 1'b1;
		end else if (upd_ir) begin
			hi_sel_reg <= 1'b0;
			first_reg <= 1'b1;
		end else if ((upd_dr && sel_load) || (cap_dr && sel_read)) begin
			hi_sel_reg <= ~hi_sel_reg;
			first_reg <= 1'b0;
		end
	end

	// Load pre-increments before low bytes; read post-increments after high
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			addr_reg <= 16'h0000;
		end else if (upd_dr && sel_load && !hi_sel_reg && !first_reg) begin
			addr_reg <= addr_reg + 16'h0001;
		end else if (cap_dr && sel_read && hi_sel_reg) begin
			addr_reg <= addr_reg + 16'h0001;
		end else if (addr_wr) begin
			addr_reg <= wdata_reg[15:0];
		end
	end

	// Update copies the byte; the buffer write follows two clocks after the update
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			temp_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			PAGE_WR_OUT <= 1'b0;
			PAGE_HIGH_OUT <= 1'b0;
			PAGE_DATA_OUT <= 8'h00;
		end else begin
			wr_pend_reg <= upd_dr && sel_load;
			PAGE_WR_OUT <= wr_pend_reg;
			if (upd_dr && sel_load) begin
				temp_reg <= cmd_sr_reg[7:0];
				PAGE_HIGH_OUT <= hi_sel_reg;
			end
			if (wr_pend_reg) begin
				PAGE_DATA_OUT <= temp_reg;
			end
		end
	end

	sequence load_update_s;
		upd_dr && sel_load;
	endsequence
	page_write_a: assert property (load_update_s |-> ##2 PAGE_WR_OUT
		&& PAGE_DATA_OUT == $past(cmd_sr_reg[7:0], 2))
		else $error("Page buffer write missing or wrong byte");
	byte_toggle_a: assert property (load_update_s |=> hi_sel_reg != $past(hi_sel_reg))
		else $error("Page load byte select did not alternate");
	load_incr_a: assert property (load_update_s and (first_reg || hi_sel_reg)
		|=> addr_reg == $past(addr_reg) || $past(addr_wr))
		else $error("Address moved on first or high byte");
	read_incr_a: assert property (cap_dr && sel_read && hi_sel_reg
		|=> addr_reg == $past(addr_reg) + 16'h0001)
		else $error("Address not incremented after high byte");

	// ----------------------------------------------------------------
	// Array command, execute pulse and device reset
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ARRAY_EXEC_OUT <= 1'b0;
		end else begin
			// Leaving Update-IR still selects the old instruction, so the pulse is masked then
			ARRAY_EXEC_OUT <= idle_entry && sel_cmd && !upd_ir;
		end
	end

	exec_gate_a: assert property (ARRAY_EXEC_OUT |-> $past(sel_cmd)
		&& tap_reg == TAP_IDLE && $past(tap_reg) != TAP_IDLE)
		else $error("Execute pulse outside command idle entry");

	logic [11:0] tmo_cnt_reg, tmo_load;
	logic chain_d_reg;
	always_comb begin
		unique case (tmo_s2_reg)
			2'h0: tmo_load = 12'(`RST_TMO_CYC_0);
			2'h1: tmo_load = 12'(`RST_TMO_CYC_1);
			2'h2: tmo_load = 12'(`RST_TMO_CYC_2);
			2'h3: tmo_load = 12'(`RST_TMO_CYC_3);
		endcase
	end

	// Time-out starts when the chain is released
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			chain_d_reg <= 1'b0;
			tmo_cnt_reg <= 12'h000;
		end else begin
			chain_d_reg <= chain_reg;
			if (chain_d_reg && !chain_reg) begin
				tmo_cnt_reg <= tmo_load;
			end else if (tmo_cnt_reg != 12'h000) begin
				tmo_cnt_reg <= tmo_cnt_reg - 12'h001;
			end
		end
	end

	// Chain bit acts unlatched, straight onto the reset line
	assign DEVICE_RESET_OUT = chain_reg | chain_d_reg | (tmo_cnt_reg != 12'h000);
	assign ARRAY_CMD_OUT = cmd_reg;
	assign WORD_ADDR_OUT = addr_reg;

	chain_reset_a: assert property (sh_dr && sel_chain && tdi |=> DEVICE_RESET_OUT)
		else $error("Reset chain set but device not in reset");
	timeout_hold_a: assert property ($fell(chain_reg) |-> DEVICE_RESET_OUT [*2])
		else $error("Device left reset without time-out");
	disable_clear_a: assert property (disable_reg && !ext_reset_n [*3]
		|-> ##[0:1] !disable_reg)
		else $error("Disable bit not cleared under held reset");

	// ----------------------------------------------------------------
	// TDO, changed on falling TCK
	// ----------------------------------------------------------------
	logic tdo_reg, tdo_en_n_reg, dr_lsb;
	always_comb begin
		if (sel_chain) begin
			dr_lsb = chain_reg;
		end else if (sel_unlock) begin
			dr_lsb = enable_reg[0];
		end else if (sel_cmd || sel_load || sel_read) begin
			dr_lsb = cmd_sr_reg[0];
		end else begin
			dr_lsb = bypass_reg;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tdo_reg <= 1'b0;
			tdo_en_n_reg <= 1'b1;
		end else if (tck_fall) begin
			tdo_reg <= tap_reg == TAP_SH_IR ? ir_sr_reg[0] : dr_lsb;
			tdo_en_n_reg <= !(tap_reg == TAP_SH_IR || tap_reg == TAP_SH_DR);
		end
	end
	assign TDO_OUT = tdo_reg;
	assign TDO_EN_N_OUT = tdo_en_n_reg;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic aw_full_reg, w_full_reg;
	logic [3:0] awaddr_reg;
	logic wr_go;
	assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
	assign wr_go = aw_full_reg && w_full_reg && !S_AXI_BVALID;
	assign ctrl_wr = wr_go && awaddr_reg == `OFS_CORE_CTRL;
	assign addr_wr = wr_go && awaddr_reg == `OFS_WORD_ADDR && wstrb_reg[1:0] == 2'h3;

	// Address and data are taken in either order; response after both
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (awaddr_reg == `OFS_CORE_CTRL || awaddr_reg == `OFS_WORD_ADDR)
					? 2'h0 : 2'h2;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Reads answer one clock after the address; unmapped gives SLVERR
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= 2'h0;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= 2'h0;
			unique case (S_AXI_ARADDR)
				`OFS_CORE_CTRL: S_AXI_RDATA <= {31'h0, disable_reg};
				`OFS_STATUS: S_AXI_RDATA <= {24'h0, ir_reg, DEVICE_RESET_OUT,
					chain_reg, prog_mode_reg, port_enable};
				`OFS_WORD_ADDR: S_AXI_RDATA <= {16'h0, addr_reg};
				`OFS_COMMAND: S_AXI_RDATA <= {17'h0, cmd_reg};
				default: begin
					S_AXI_RDATA <= 32'h00000000;
					S_AXI_RRESP <= 2'h2;
				end
			endcase
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule // jtag_prog_path

`default_nettype wire

// >>> bench/jtag_programmer.sv
/*
 * Model of the external programmer: drives test clock, mode select and data in.
 * Assumes the block samples the test clock with a faster core clock.
 */
`default_nettype none
module jtag_programmer (
	input wire logic tdo_in,
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock stands low between frames
	initial begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h0;
	end
	// One 800 ns period, well under the core clock rate; TDO read at the rise
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		tms_out <= tms;
		tdi_out <= tdi;
		#400 tck_out <= 1'h1;
		tdo = tdo_in;
		#400 tck_out <= 1'h0;
	endtask
	// Five high mode bits reach Test-Logic-Reset, then park in Idle
	task automatic tap_reset();
		logic t;
		repeat (5) tick(1'h1, ~tdi_out, t);
		tick(1'h0, ~tdi_out, t);
	endtask
	// Idle, shift n bits least significant first, Update, back to Idle
	task automatic scan(input logic ir, input logic [15:0] v, input int n,
		output logic [15:0] got);
		logic t;
		got = 16'h0;
		tick(1'h1, ~tdi_out, t);
		if (ir) tick(1'h1, ~tdi_out, t);
		repeat (2) tick(1'h0, ~tdi_out, t);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, v[i], t);
			got[i] = t;
		end
		// Data line toggles twice, so it is left showing the last bit
		tick(1'h1, ~tdi_out, t);
		tick(1'h0, ~tdi_out, t);
	endtask
endmodule // jtag_programmer
`default_nettype wire

// >>> bench/jtag_programming_data_path_tb.sv
/*
 * Self-checking bench for the programming path: bus, reset chain, unlock,
 * commands, page load and page read. Assumes the programmer model beside it.
 */
`include "jtag_prog_defs.svh"
`default_nettype none
module jtag_programming_data_path_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, tck, tms, tdi, tdo, tdo_en_n, tdo_line, ext_rst_n, fuse, dev_rst, exec;
	logic page_wr, page_hi, awv, awr, wv, wr, bv, bready, arv, arr, rv, rready;
	logic [1:0] tmo, bresp, rresp;
	logic [3:0] awaddr, araddr, wstrb;
	logic [7:0] page_data;
	logic [14:0] cmd, result;
	logic [15:0] word_addr, array_word;
	logic [31:0] wdata, rdata;
	int mismatches, samples_checked, exec_count;
	logic [24:0] pq[$];
	// Array contents as a simple function of the word address
	function automatic logic [15:0] word_of(input logic [15:0] ad);
		return ad ^ 16'h5AC3;
	endfunction
	assign array_word = word_of(word_addr);
	assign tdo_line = tdo_en_n ? 1'h1 : tdo; // Pull-up while TDO is released
	always #50 clk = ~clk;
	jtag_programmer prog (.tdo_in(tdo_line), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
	jtag_prog_path dut (.CLOCK_IN(clk), .RST_IN(rst), .TCK_IN(tck), .TMS_IN(tms),
		.TDI_IN(tdi), .TDO_OUT(tdo), .TDO_EN_N_OUT(tdo_en_n), .EXT_RESET_N_IN(ext_rst_n),
		.TEST_PORT_ENABLE_FUSE_IN(fuse), .RESET_TIMEOUT_FUSE_IN(tmo),
		.DEVICE_RESET_OUT(dev_rst), .ARRAY_CMD_OUT(cmd), .ARRAY_EXEC_OUT(exec),
		.ARRAY_RESULT_IN(result), .PAGE_WR_OUT(page_wr), .PAGE_HIGH_OUT(page_hi),
		.PAGE_DATA_OUT(page_data), .WORD_ADDR_OUT(word_addr), .ARRAY_WORD_IN(array_word),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
	// Record page buffer writes and count command pulses
	always @(posedge clk) begin
		if (page_wr === 1'h1) pq.push_back({page_hi, word_addr, page_data});
		if (exec === 1'h1) exec_count++;
	end
	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One bus transfer; ready and valid are sampled mid-cycle, acted on at the edge
	task automatic axi(input logic w, input logic [3:0] ad, input logic [31:0] dt,
		output logic [31:0] rd, output logic [1:0] rs);
		logic pa, pw, done, ta, tw;
		int n;
		pa = 1'h1;
		pw = w;
		done = 1'h0;
		n = 0;
		@(posedge clk);
		if (w) begin
			awaddr <= ad; wdata <= dt; awv <= 1'h1; wv <= 1'h1; bready <= 1'h1;
		end else begin
			araddr <= ad; arv <= 1'h1; rready <= 1'h1;
		end
		while (!done) begin
			@(negedge clk);
			ta = pa & (w ? awr : arr);
			tw = pw & wr;
			done = !pa & !pw & (w ? bv : rv);
			rd = rdata;
			rs = w ? bresp : rresp;
			@(posedge clk);
			if (ta) begin
				awv <= 1'h0; arv <= 1'h0; pa = 1'h0;
			end
			if (tw) begin
				wv <= 1'h0; pw = 1'h0;
			end
			if (done) begin
				bready <= 1'h0; rready <= 1'h0;
			end
			if (++n > 100) begin
				mismatches++; finish_test();
			end
		end
	endtask
	// Watchdog against a hang
	initial begin
		#5000000;
		mismatches++;
		finish_test();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] got, a, w;
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] b[4];
		logic [14:0] c;
		int e, n;
		clk = 1'h0; rst = 1'h1; ext_rst_n = 1'h1; fuse = 1'h1; tmo = 2'h3; result = 15'h0;
		awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hF;
		awv = 1'h0; wv = 1'h0; bready = 1'h0; arv = 1'h0; rready = 1'h0;
		mismatches = 0; samples_checked = 0; exec_count = 0;
		void'($urandom(32'h64FD));
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		axi(1'h1, `OFS_STATUS, 32'h1, d, r);
		check("ro write resp", r, 2'h2);
		axi(1'h1, `OFS_CORE_CTRL, 32'h1, d, r);
		check("ctrl write resp", r, 2'h0);
		axi(1'h0, `OFS_STATUS, 32'h0, d, r);
		check("port enable off", d[0], 1'h0);
		check("read resp", r, 2'h0);
		@(posedge clk) ext_rst_n <= 1'h0;
		repeat (6) @(posedge clk);
		ext_rst_n <= 1'h1;
		axi(1'h0, `OFS_CORE_CTRL, 32'h0, d, r);
		check("disable bit", d[0], 1'h0);
		axi(1'h0, `OFS_STATUS, 32'h0, d, r);
		check("port enable on", d[0], 1'h1);
		@(posedge clk) fuse <= 1'h0;
		repeat (3) @(posedge clk);
		axi(1'h0, `OFS_STATUS, 32'h0, d, r);
		check("fuse off", d[0], 1'h0);
		fuse <= 1'h1;
		// Reset the device through the chain before unlocking
		prog.tap_reset();
		prog.scan(1'h1, `IR_CHAIN_RESET, 4, got);
		check("ir capture", got[3:0], `IR_CAPTURE);
		// Two time-out selections, each counted from the end of the releasing scan
		for (int k = 3; k >= 2; k--) begin
			@(posedge clk) tmo <= 2'(k);
			prog.scan(1'h0, 16'h1, 1, got);
			check("chain reset", dev_rst, 1'h1);
			prog.scan(1'h0, 16'h0, 1, got);
			check("reset hold", dev_rst, 1'h1);
			e = k == 3 ? `RST_TMO_CYC_3 : `RST_TMO_CYC_2;
			n = 0;
			while (dev_rst === 1'h1 && n < 5000) begin
				@(posedge clk);
				n++;
			end
			check("time-out length", n > e - 100 && n < e + 2, 1'h1);
		end
		prog.scan(1'h1, `IR_PROG_UNLOCK, 4, got);
		prog.scan(1'h0, `UNLOCK_SIGNATURE ^ 16'h0100, 16, got);
		axi(1'h0, `OFS_STATUS, 32'h0, d, r);
		check("prog mode off", d[1], 1'h0);
		prog.scan(1'h0, `UNLOCK_SIGNATURE, 16, got);
		axi(1'h0, `OFS_STATUS, 32'h0, d, r);
		check("prog mode on", d[1], 1'h1);
		check("ir value", d[7:4], `IR_PROG_UNLOCK);
		// Commands: old result out, new command applied, one pulse per idle pass
		prog.scan(1'h1, `IR_PROG_COMMAND, 4, got);
		repeat (4) begin
			c = 15'($urandom);
			@(posedge clk) result <= 15'($urandom);
			e = exec_count;
			prog.scan(1'h0, {1'h0, c}, 15, got);
			repeat (4) @(posedge clk);
			check("result", got[14:0], result);
			check("command", cmd, c);
			check("exec pulses", exec_count - e, 1);
		end
		axi(1'h0, `OFS_COMMAND, 32'h0, d, r);
		check("command reg", d, {17'h0, c});
		a = 16'($urandom);
		axi(1'h1, `OFS_WORD_ADDR, {16'h0, a}, d, r);
		prog.scan(1'h1, `IR_PAGE_LOAD, 4, got);
		for (int i = 0; i < 4; i++) begin
			b[i] = 8'($urandom);
			prog.scan(1'h0, {8'h0, b[i]}, 8, got);
		end
		repeat (4) @(posedge clk);
		check("page writes", pq.size(), 4);
		check("exec on exit", exec_count - e, 1);
		for (int i = 0; i < 4; i++) check("page load", pq[i], {i[0], a + 16'(i / 2), b[i]});
		prog.scan(1'h1, `IR_PAGE_READ, 4, got);
		for (int i = 0; i < 4; i++) begin
			prog.scan(1'h0, 16'h0, 8, got);
			w = word_of(a + 16'h1 + 16'(i / 2));
			check("page read", got[7:0], i[0] ? w[15:8] : w[7:0]);
		end
		check("post increment", word_addr, 16'(a + 16'h3));
		// Leave programming mode with a non-matching value
		prog.scan(1'h1, `IR_PROG_UNLOCK, 4, got);
		prog.scan(1'h0, 16'h0, 16, got);
		axi(1'h0, `OFS_STATUS, 32'h0, d, r);
		check("prog mode left", d[1], 1'h0);
		finish_test();
	end
endmodule // jtag_programming_data_path_tb
`default_nettype wire
